/* File: src/fdcu_map.vh */
// register offsets, status and interrupt bit positions and timing counts of the disk command unit
`ifndef FDCU_MAP_VH
`define FDCU_MAP_VH
`define FDCU_ADDR_STATUS 12'h000
`define FDCU_ADDR_TRACK 12'h004
`define FDCU_ADDR_SECTOR 12'h008
`define FDCU_ADDR_DATA 12'h00C
`define FDCU_ADDR_IRQ_STAT 12'h010
`define FDCU_ADDR_IRQ_MASK 12'h014
`define FDCU_ADDR_ID_TRACK 12'h018
`define FDCU_ADDR_ID_SECTOR 12'h01C
`define FDCU_ADDR_CMD_MODE 12'h020
`define FDCU_ST_BUSY 0
`define FDCU_ST_RNF 4
`define FDCU_IRQ_DONE 0
`define FDCU_IRQ_RNF 1
`define FDCU_IRQ_FORCE 2
`define FDCU_IRQ_INDEX 3
`define FDCU_STEP_NS 3000
`define FDCU_STEP_CYC ((`FDCU_STEP_NS + 9) / 10)
`define FDCU_REVS 2
`endif

/* File: src/fdcu_top.v */
// disk command unit: decoder, head stepper, id search and apb register file
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "fdcu_map.vh"

// Functional notes
// - upper bits 100 decode as sector read; m, b, E flags; low bits zero.
// - upper bits 101 decode as sector write; low two bits pick data mark.
// - pattern 11000, E flag, low bits zero decode as read address.
// - pattern 11100, E flag, bit1 zero, sync bit0 decode as read track.
// - pattern 11110, E flag, low bits zero decode as write track.
// - upper bits 1101 force interrupt; low four bits pick raising conditions.
// - restore steps outward until track zero, then track register becomes zero.
// - seek steps toward destination while track and data registers differ.
// - when equal, seek ends and raises interrupt.
// - step in/out move exactly one track and record direction.
// - plain step moves one track in last used direction.
// - id field matches only with valid track, sector and crc.
// - no match within two index revolutions ends the command with interrupt.
// - failed id search sets record-not-found at status bit 4.
// - read address reads next id field and hands bytes to host.
// - force interrupt accepted any time, aborts command; raises interrupt only for the conditions its low bits pick.
// - select lines with strobe choose status/command, track, sector, data.
module fdcu_top (
  input wire clock_i,
  input wire rst_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  input wire index_i,
  input wire track00_i,
  input wire id_valid_i,
  input wire crc_ok_i,
  input wire [7:0] id_track_i,
  input wire [7:0] id_sector_i,
  output reg step_o,
  output reg step_dir_in_o,
  output reg write_gate_o,
  output reg [1:0] data_mark_o,
  output reg irq_o
);

  // sequencer states
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_STEP = 3'h1;
  localparam [2:0] S_WAIT = 3'h2;
  localparam [2:0] S_SRCH = 3'h3;
  localparam [2:0] S_XFER = 3'h4;
  localparam [2:0] S_DONE = 3'h5;

  // decoded command kinds; all head moves sort below K_READ
  localparam [3:0] K_NONE = 4'h0;
  localparam [3:0] K_RESTORE = 4'h1;
  localparam [3:0] K_SEEK = 4'h2;
  localparam [3:0] K_STEP = 4'h3;
  localparam [3:0] K_STEP_IN = 4'h4;
  localparam [3:0] K_STEP_OUT = 4'h5;
  localparam [3:0] K_READ = 4'h6;
  localparam [3:0] K_WRITE = 4'h7;
  localparam [3:0] K_RADDR = 4'h8;
  localparam [3:0] K_RTRACK = 4'h9;
  localparam [3:0] K_WTRACK = 4'hA;
  localparam [3:0] K_FORCE = 4'hB;
  // step spacing in controller clocks
  localparam [15:0] STEP_CYC = `FDCU_STEP_CYC;

  // classify an 8-bit command word; illegal forms decode as none
  function [3:0] decode;
    input [7:0] c;
    begin
      casez (c)
        8'b0000_????: decode = K_RESTORE;
        8'b0001_????: decode = K_SEEK;
        8'b001?_????: decode = K_STEP;
        8'b010?_????: decode = K_STEP_IN;
        8'b011?_????: decode = K_STEP_OUT;
        8'b100?_??00: decode = K_READ;
        8'b101?_????: decode = K_WRITE;
        8'b1100_0?00: decode = K_RADDR;
        8'b1110_0?0?: decode = K_RTRACK;
        8'b1111_0?00: decode = K_WTRACK;
        8'b1101_????: decode = K_FORCE;
        default: decode = K_NONE;
      endcase
    end
  endfunction

  // true for every address the host may reach; the rest answer with an error
  function reg_hit;
    input [11:0] a;
    begin
      case (a)
        `FDCU_ADDR_STATUS,
        `FDCU_ADDR_TRACK,
        `FDCU_ADDR_SECTOR,
        `FDCU_ADDR_DATA,
        `FDCU_ADDR_IRQ_STAT,
        `FDCU_ADDR_IRQ_MASK,
        `FDCU_ADDR_ID_TRACK,
        `FDCU_ADDR_ID_SECTOR,
        `FDCU_ADDR_CMD_MODE:
          reg_hit = 1'b1;
        default: reg_hit = 1'b0;
      endcase
    end
  endfunction

  // the index line has a third stage only for its edge detector
  reg idx_s1_q, idx_s2_q, idx_s3_q;
  reg t0_s1_q, t0_s2_q;
  reg idv_s1_q, idv_s2_q, crc_s1_q, crc_s2_q;
  reg [7:0] idt_s1_q, idt_s2_q, ids_s1_q, ids_s2_q;
  reg [7:0] track_q, sector_q, data_q, cmd_q, id_trk_q, id_sec_q;
  reg [3:0] kind_q, force_cond_q;
  reg [2:0] state_q;
  reg [15:0] tmr_q;
  reg [1:0] revs_q;
  reg busy_q, rnf_q, dir_in_q;
  reg [3:0] irq_stat_q, irq_mask_q;

  wire index_rise = idx_s2_q & ~idx_s3_q;
  wire idv = idv_s2_q;
  wire id_match = idv & crc_s2_q & (idt_s2_q == track_q) & (ids_s2_q == sector_q);
  wire apb_wr = psel_i & penable_i & pwrite_i;
  wire apb_rd = psel_i & penable_i & ~pwrite_i;
  wire cmd_wr = apb_wr & (paddr_i == `FDCU_ADDR_STATUS);
  wire [3:0] cmd_kind = decode(pwdata_i[7:0]);
  wire hit = reg_hit(paddr_i);
  // host writes land on the first access edge only, never again while ready is up
  wire wr_take = apb_wr & ~pready_o;
  wire wr_track = wr_take & (paddr_i == `FDCU_ADDR_TRACK);
  wire wr_sector = wr_take & (paddr_i == `FDCU_ADDR_SECTOR);
  wire wr_data = wr_take & (paddr_i == `FDCU_ADDR_DATA);
  wire wr_mask = wr_take & (paddr_i == `FDCU_ADDR_IRQ_MASK);
  wire rd_clear = apb_rd & ~pready_o & (paddr_i == `FDCU_ADDR_IRQ_STAT);
  wire force_wr = cmd_wr & ~pready_o & (cmd_kind == K_FORCE);
  wire cmd_take = cmd_wr & ~pready_o & ~busy_q & (cmd_kind != K_NONE);
  // the search ends on the first acceptable id field for the command in hand
  wire raddr_hit = (kind_q == K_RADDR) & idv & crc_s2_q;
  wire sect_hit = (kind_q != K_RADDR) & id_match;
  wire [7:0] status_v = {3'h0, rnf_q, 3'h0, busy_q};

  reg ev_done, ev_rnf, ev_force, ev_index;
  reg [31:0] rdata_d;

  // read mux; unmapped addresses read zero
  always @* begin
    rdata_d = 32'h0000_0000;
    case (paddr_i)
      `FDCU_ADDR_STATUS: rdata_d = {24'h0, status_v};
      `FDCU_ADDR_TRACK: rdata_d = {24'h0, track_q};
      `FDCU_ADDR_SECTOR: rdata_d = {24'h0, sector_q};
      `FDCU_ADDR_DATA: rdata_d = {24'h0, data_q};
      `FDCU_ADDR_IRQ_STAT: rdata_d = {28'h0, irq_stat_q};
      `FDCU_ADDR_IRQ_MASK: rdata_d = {28'h0, irq_mask_q};
      `FDCU_ADDR_ID_TRACK: rdata_d = {24'h0, id_trk_q};
      `FDCU_ADDR_ID_SECTOR: rdata_d = {24'h0, id_sec_q};
      `FDCU_ADDR_CMD_MODE: rdata_d = {20'h0, kind_q, cmd_q};
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // events that feed the sticky interrupt status, one cycle wide each
  always @* begin
    ev_done = (state_q == S_DONE);
    ev_rnf = (state_q == S_SRCH) & ~raddr_hit & ~sect_hit & (revs_q == `FDCU_REVS);
    ev_force = force_wr & pwdata_i[3];
    // index events only while a forced interrupt has armed that condition
    ev_index = force_cond_q[2] & index_rise;
  end

  // drive inputs are asynchronous to the controller clock
  always @(posedge clock_i) begin
    idx_s1_q <= index_i;
    idx_s2_q <= idx_s1_q;
    idx_s3_q <= idx_s2_q;
    t0_s1_q <= track00_i;
    t0_s2_q <= t0_s1_q;
    idv_s1_q <= id_valid_i;
    idv_s2_q <= idv_s1_q;
    crc_s1_q <= crc_ok_i;
    crc_s2_q <= crc_s1_q;
    idt_s1_q <= id_track_i;
    idt_s2_q <= idt_s1_q;
    ids_s1_q <= id_sector_i;
    ids_s2_q <= ids_s1_q;
  end

  // every access is answered after exactly one wait state
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      // one wait state: ready rises on the second access cycle
      pready_o <= psel_i & penable_i & ~pready_o;
      pslverr_o <= psel_i & penable_i & ~pready_o & ~hit;
      prdata_o <= rdata_d;
    end
  end

  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      track_q <= 8'h00;
      sector_q <= 8'h00;
      data_q <= 8'h00;
      cmd_q <= 8'h00;
      kind_q <= K_NONE;
      force_cond_q <= 4'h0;
      state_q <= S_IDLE;
      tmr_q <= 16'h0000;
      revs_q <= 2'h0;
      busy_q <= 1'b0;
      rnf_q <= 1'b0;
      dir_in_q <= 1'b0;
      id_trk_q <= 8'h00;
      id_sec_q <= 8'h00;
      irq_mask_q <= 4'h0;
      step_o <= 1'b0;
      step_dir_in_o <= 1'b0;
      write_gate_o <= 1'b0;
      data_mark_o <= 2'h0;
    end else begin
      step_o <= 1'b0;
      // host register writes; the sequencer below may override track and data
      if (wr_track) track_q <= pwdata_i[7:0];
      if (wr_sector) sector_q <= pwdata_i[7:0];
      if (wr_data) data_q <= pwdata_i[7:0];
      if (wr_mask) irq_mask_q <= pwdata_i[3:0];
      case (state_q)
        S_STEP: begin
          // restore has no target: track zero is known only from the drive line
          if (kind_q == K_RESTORE && t0_s2_q) begin
            track_q <= 8'h00;
            state_q <= S_DONE;
          end else if (kind_q == K_SEEK && track_q == data_q) begin
            state_q <= S_DONE;
          end else begin
            step_o <= 1'b1;
            step_dir_in_o <= dir_in_q;
            if (kind_q != K_RESTORE) begin
              track_q <= dir_in_q ? track_q + 8'h01 : track_q - 8'h01;
            end
            tmr_q <= STEP_CYC;
            state_q <= S_WAIT;
          end
        end
        S_WAIT: begin
          // the drive needs the full step time before the next pulse or the end
          if (tmr_q != 16'h0000) begin
            tmr_q <= tmr_q - 16'h0001;
          end else if (kind_q == K_RESTORE || kind_q == K_SEEK) begin
            state_q <= S_STEP;
          end else begin
            state_q <= S_DONE;
          end
        end
        S_SRCH: begin
          // revolutions are counted on the synchronised index edge
          if (index_rise) revs_q <= revs_q + 2'h1;
          if (raddr_hit) begin
            id_trk_q <= idt_s2_q;
            id_sec_q <= ids_s2_q;
            data_q <= idt_s2_q;
            state_q <= S_DONE;
          end else if (sect_hit) begin
            id_trk_q <= idt_s2_q;
            id_sec_q <= ids_s2_q;
            write_gate_o <= (kind_q == K_WRITE);
            state_q <= S_XFER;
          end else if (revs_q == `FDCU_REVS) begin
            rnf_q <= 1'b1;
            state_q <= S_DONE;
          end
        end
        S_XFER: begin
          // sector payload moves in the datapath; end the record at id drop
          if (~idv) begin
            write_gate_o <= 1'b0;
            state_q <= S_DONE;
          end
        end
        S_DONE: begin
          busy_q <= 1'b0;
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
      // a forced interrupt overrides whatever the sequencer was doing
      if (force_wr) begin
        cmd_q <= pwdata_i[7:0];
        kind_q <= K_FORCE;
        force_cond_q <= pwdata_i[3:0];
        busy_q <= 1'b0;
        write_gate_o <= 1'b0;
        state_q <= S_IDLE;
      end else if (cmd_take) begin
        // any other command is dropped, not queued, while busy
        cmd_q <= pwdata_i[7:0];
        kind_q <= cmd_kind;
        busy_q <= 1'b1;
        rnf_q <= 1'b0;
        revs_q <= 2'h0;
        force_cond_q <= 4'h0;
        data_mark_o <= pwdata_i[1:0];
        if (cmd_kind == K_STEP_IN) dir_in_q <= 1'b1;
        if (cmd_kind == K_STEP_OUT || cmd_kind == K_RESTORE) dir_in_q <= 1'b0;
        if (cmd_kind == K_SEEK) dir_in_q <= (data_q > track_q);
        if (cmd_kind <= K_STEP_OUT) state_q <= S_STEP;
        else if (cmd_kind == K_RTRACK || cmd_kind == K_WTRACK) state_q <= S_XFER;
        else state_q <= S_SRCH;
      end
    end
  end

  // a read of the interrupt status clears it, but an event in the same cycle wins
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      irq_stat_q <= 4'h0;
      irq_o <= 1'b0;
    end else begin
      if (rd_clear) begin
        irq_stat_q <= {ev_index, ev_force, ev_rnf, ev_done};
      end else begin
        irq_stat_q <= irq_stat_q | {ev_index, ev_force, ev_rnf, ev_done};
      end
      // the level output lags the sticky bits by one clock
      irq_o <= |(irq_stat_q & irq_mask_q);
    end
  end

endmodule

/* File: verif/fdcu_props.sv */
// port assertions of the disk command unit
`timescale 1ns/1ps
module fdcu_props (
  input wire clock_i,
  input wire rst_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  input wire step_o,
  input wire irq_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  AST_READY_ONE: assert property (pready_o |=> !pready_o)
    else $error("ready held past one cycle");
  AST_WAIT_ONE: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("ready not one cycle after access");
  AST_ERR_PAIR: assert property (pslverr_o |-> pready_o)
    else $error("slave error without ready");
  AST_MAPPED: assert property (pready_o && paddr_i <= 12'h020 && paddr_i[1:0] == 2'h0 |-> !pslverr_o)
    else $error("error on mapped register");
  AST_UNMAPPED: assert property (pready_o && paddr_i > 12'h020 |-> pslverr_o && (pwrite_i || prdata_o == 32'h0))
    else $error("unmapped access not refused");
  AST_BYTE_REG: assert property (pready_o && !pwrite_i && paddr_i <= 12'h00C |-> prdata_o[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  AST_STEP_GAP: assert property (step_o |=> !step_o [*8])
    else $error("step pulses too close");
  // the reset check must see the cycle right after release, so it is never disabled
  AST_RST_QUIET: assert property (disable iff (1'b0) !rst_n_i |=> !pready_o && !step_o && !irq_o)
    else $error("outputs active out of reset");
endmodule

/* File: verif/fdcu_drive_model.sv */
// drive-side model: head position, index pulse and one id field per revolution
`timescale 1ns/1ps
module fdcu_drive_model (
  input wire clock_i,
  input wire rst_n_i,
  input wire step_i,
  input wire dir_in_i,
  input wire crc_bad_i,
  output logic index_o,
  output logic track00_o,
  output logic id_valid_o,
  output logic crc_ok_o,
  output logic [7:0] id_track_o,
  output logic [7:0] id_sector_o,
  output logic [7:0] head_o
);
  int cyc;
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      cyc <= 0;
      head_o <= 8'h02;
    end else begin
      cyc <= (cyc == 999) ? 0 : cyc + 1;
      if (step_i && dir_in_i)
        head_o <= head_o + 8'h01;
      if (step_i && !dir_in_i && head_o != 8'h00)
        head_o <= head_o - 8'h01;
    end
  end
  assign index_o = cyc < 20;
  assign track00_o = head_o == 8'h00;
  assign id_valid_o = cyc >= 400 && cyc < 440;
  // outside the field the id lines carry junk, never the last value
  assign id_track_o = id_valid_o ? head_o : ~head_o;
  assign id_sector_o = id_valid_o ? 8'h03 : 8'hFC;
  assign crc_ok_o = id_valid_o ? !crc_bad_i : cyc[0];
endmodule

/* File: verif/tb.sv */
// self-checking bench of the disk command unit
`timescale 1ns/1ps
`include "fdcu_map.vh"
module tb;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic crc_bad = 1'b0;
  logic wg_seen = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd, rd;
  logic rdy, err, rerr, idx, t0, idv, crc, step, din, wg, irq, dir;
  logic [7:0] idt, ids, head;
  logic [1:0] mark;
  int num_errors = 0;
  int total_checks = 0;
  int steps = 0;
  always #5 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    if (step) begin
      steps <= steps + 1;
      dir <= din;
    end
    if (wg)
      wg_seen <= 1'b1;
  end
  fdcu_top fdcu_top_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy),
    .pslverr_o(err), .index_i(idx), .track00_i(t0), .id_valid_i(idv), .crc_ok_i(crc),
    .id_track_i(idt), .id_sector_i(ids), .step_o(step), .step_dir_in_o(din),
    .write_gate_o(wg), .data_mark_o(mark), .irq_o(irq));
  fdcu_drive_model fdcu_drive_model_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .step_i(step),
    .dir_in_i(din), .crc_bad_i(crc_bad), .index_o(idx), .track00_o(t0), .id_valid_o(idv),
    .crc_ok_o(crc), .id_track_o(idt), .id_sector_o(ids), .head_o(head));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic hang;
    num_errors++;
    complete_run();
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clock_i);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clock_i);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (rdy !== 1'b1 && n < 50);
    if (rdy !== 1'b1)
      hang();
    rd = prd;
    rerr = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic cmd(input logic [7:0] c);
    int n;
    wr(`FDCU_ADDR_STATUS, {24'h0, c});
    for (n = 0; n < 3000; n++) begin
      apb(1'b0, `FDCU_ADDR_STATUS, 32'h0);
      if (rd[`FDCU_ST_BUSY] === 1'b0)
        return;
    end
    hang();
  endtask
  task automatic t_regs;
    rchk(`FDCU_ADDR_TRACK, 32'h0);
    rchk(`FDCU_ADDR_STATUS, 32'h0);
    wr(`FDCU_ADDR_SECTOR, 32'h5A);
    rchk(`FDCU_ADDR_SECTOR, 32'h5A);
    rchk(12'h040, 32'h0);
    chk(rerr, 1);
    wr(`FDCU_ADDR_IRQ_MASK, 32'hF);
    wr(`FDCU_ADDR_STATUS, 32'h81);
    rchk(`FDCU_ADDR_STATUS, 32'h0);
  endtask
  task automatic move(input logic [7:0] c, input int n, input logic d, input logic [7:0] t);
    int s0;
    s0 = steps;
    cmd(c);
    chk(steps - s0, n);
    chk(dir, d);
    rchk(`FDCU_ADDR_TRACK, t);
    chk(head, t);
    chk(irq, 1);
    rchk(`FDCU_ADDR_IRQ_STAT, 32'h1);
  endtask
  task automatic t_sector;
    wr(`FDCU_ADDR_SECTOR, 32'h3);
    cmd(8'h80);
    rchk(`FDCU_ADDR_STATUS, 32'h0);
    rchk(`FDCU_ADDR_IRQ_STAT, 32'h1);
    wr(`FDCU_ADDR_SECTOR, 32'h9);
    cmd(8'h90);
    rchk(`FDCU_ADDR_STATUS, 32'h10);
    rchk(`FDCU_ADDR_IRQ_STAT, 32'h3);
    wr(`FDCU_ADDR_SECTOR, 32'h3);
    crc_bad <= 1'b1;
    cmd(8'h8C);
    rchk(`FDCU_ADDR_IRQ_STAT, 32'h3);
    crc_bad <= 1'b0;
    cmd(8'hC0);
    rchk(`FDCU_ADDR_ID_TRACK, 32'h2);
    rchk(`FDCU_ADDR_DATA, 32'h2);
    rchk(`FDCU_ADDR_IRQ_STAT, 32'h1);
    cmd(8'hA2);
    chk(mark, 2);
    chk(wg_seen, 1);
    rchk(`FDCU_ADDR_IRQ_STAT, 32'h1);
    cmd(8'hE5);
    rchk(`FDCU_ADDR_IRQ_STAT, 32'h1);
    cmd(8'hF4);
    rchk(`FDCU_ADDR_IRQ_STAT, 32'h1);
  endtask
  task automatic t_force;
    wr(`FDCU_ADDR_STATUS, 32'hD0);
    rchk(`FDCU_ADDR_IRQ_STAT, 32'h0);
    wr(`FDCU_ADDR_DATA, 32'h9);
    wr(`FDCU_ADDR_STATUS, 32'h10);
    apb(1'b0, `FDCU_ADDR_STATUS, 32'h0);
    chk(rd[0], 1);
    wr(`FDCU_ADDR_STATUS, 32'hD8);
    apb(1'b0, `FDCU_ADDR_STATUS, 32'h0);
    chk(rd[0], 0);
    chk(irq, 1);
    rchk(`FDCU_ADDR_IRQ_STAT, 32'h4);
  endtask
  task automatic t_index;
    int n;
    wr(`FDCU_ADDR_STATUS, 32'hD4);
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge clock_i);
      n++;
    end
    if (irq !== 1'b1)
      hang();
    rchk(`FDCU_ADDR_IRQ_STAT, 32'h8);
    wr(`FDCU_ADDR_STATUS, 32'hD0);
  endtask
  initial begin
    repeat (8) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_regs();
    move(8'h00, 2, 1'b0, 8'h00);
    wr(`FDCU_ADDR_DATA, 32'h3);
    move(8'h10, 3, 1'b1, 8'h03);
    move(8'h50, 1, 1'b1, 8'h04);
    move(8'h70, 1, 1'b0, 8'h03);
    move(8'h30, 1, 1'b0, 8'h02);
    t_sector();
    t_force();
    t_index();
    complete_run();
  end
endmodule
bind fdcu_top fdcu_props fdcu_props_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .step_o(step_o), .irq_o(irq_o));
